// *** self_prog_defines.svh ***
`ifndef SELF_PROG_DEFINES_SVH
`define SELF_PROG_DEFINES_SVH

// register offsets
`define CTRL_OFFSET      8'h00
`define LOCK_OFFSET      8'h01

// control register bit positions
`define EN_BIT           0
`define ERASE_BIT        1
`define WRITE_BIT        2
`define LOCK_BIT         3
`define REEN_BIT         4
`define BUSY_BIT         6
`define IE_BIT           7

// accepted low five control bits
`define CODE_LOAD        5'h01
`define CODE_ERASE       5'h03
`define CODE_WRITE       5'h05
`define CODE_LOCK        5'h09
`define CODE_REEN        5'h11

// arming windows in cycles
`define SPM_WINDOW       3'h4
`define LPM_WINDOW       3'h3

// pointer values for fuse and lock reads
`define PTR_FUSE_LOW     16'h0000
`define PTR_LOCK         16'h0001
`define PTR_FUSE_EXT     16'h0002
`define PTR_FUSE_HIGH    16'h0003

// reset values
`define LOCK_RESET       8'hFF
`define BUF_ERASED       16'hFFFF

// programming time
`define CLK_PERIOD_NS    100
`define PROG_MIN_NS      3700000
`define PROG_MAX_NS      4500000
`define PROG_MIN_CYCLES  ((`PROG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** self_prog_pkg.sv ***
package self_prog_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_LOCK  = 2'b11
  } op_e;

endpackage : self_prog_pkg

// *** self_program_flash_sequencer.sv ***
// What this block does
// - armed load plus store writes buffer word
// - buffer clears on write, reenable, reset
// - eeprom write start discards loaded buffer
// - armed write code starts page write
// - no_read_while_write_section page write halts cpu
// - interrupt level while enable bit clear
// - erase or write to an rww-section page blocks rww, busy set
// - reenable store clears busy flag
// - armed lock code sets boot lock bits
// - zero data bits 5..2 program locks
// - lock programming never blocks reads
// - eeprom write blocks programming, fuse reads
// - lock read returns six lock bits
// - lock-set and enable auto-clear on timeout
// - pointer 0 reads fuse low byte
// - pointer 3 reads fuse high byte
// - pointer 2 reads extended fuse bits
// - programmed reads zero, unprogrammed one
// - write in progress survives reset
// - programming lasts 3.7 to 4.5 ms
// - enable arms store for four cycles
// - only five control codes take effect
// - page load clears busy flag
// - page from Z15:Z8, word Z7:Z1
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "self_prog_defines.svh"

module self_program_flash_sequencer #(
  parameter int          PAGE_WORDS  = 128,
  parameter int          RWW_PAGES   = 224,
  parameter int          PROG_CYCLES = `PROG_MIN_CYCLES,
  parameter logic [7:0]  LOCK_INIT   = `LOCK_RESET
) (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic [7:0]             reg_rdata_out,
  input  wire logic              spm_strobe_in,
  input  wire self_prog_pkg::word_t spm_pointer_in,
  input  wire self_prog_pkg::word_t spm_data_in,
  input  wire logic              lpm_strobe_in,
  input  wire self_prog_pkg::word_t lpm_pointer_in,
  output self_prog_pkg::byte_t   lpm_data_out,
  output logic                   lpm_override_out,
  input  wire logic              eeprom_write_active_in,
  input  wire self_prog_pkg::byte_t fuse_low_byte_in,
  input  wire self_prog_pkg::byte_t fuse_high_byte_in,
  input  wire logic [1:0]        extended_fuse_bits_in,
  output logic                   flash_erase_out,
  output logic                   flash_write_out,
  output logic [7:0]             flash_page_out,
  input  wire logic [6:0]        buf_rd_addr_in,
  output self_prog_pkg::word_t   buf_rd_data_out,
  output logic                   rww_read_block_out,
  output logic                   cpu_halt_out,
  output logic                   spm_irq_out
);
  import self_prog_pkg::*;

  localparam int WA = $clog2(PAGE_WORDS);
  localparam logic [15:0] LAST_CNT = 16'(PROG_CYCLES - 1);

  logic              ctrl_en_q;
  logic [3:0]        cmd_q;
  logic [2:0]        arm_age_q;
  logic              irq_en_q;
  logic              busy_flag_q;
  op_e               op_q;
  logic [15:0]       op_cnt_q;
  logic [7:0]        op_page_q;
  logic              op_no_read_while_write_section_q;
  logic [3:0]        lock_data_q;
  logic [7:0]        lock_bits_q;
  logic              eeprom_prev_q;
  logic [PAGE_WORDS-1:0] buf_valid_q;
  word_t             buf_mem [PAGE_WORDS];
  word_t             buf_rd_q;
  logic [7:0]        rdata_q;
  byte_t             lpm_data_q;
  logic              lpm_ovr_q;

  // register bus decode
  wire ctrl_sel_w = reg_addr_in == `CTRL_OFFSET;
  wire lock_sel_w = reg_addr_in == `LOCK_OFFSET;
  wire ctrl_wr_w  = reg_write_in && ctrl_sel_w;
  wire [4:0] code_w = reg_wdata_in[4:0];
  wire code_ok_w = (code_w == `CODE_LOAD) || (code_w == `CODE_ERASE) || (code_w == `CODE_WRITE) ||
                   (code_w == `CODE_LOCK) || (code_w == `CODE_REEN);
  wire accept_w = ctrl_wr_w && code_ok_w && !ctrl_en_q && !eeprom_write_active_in;

  // armed command decode
  wire armed_w   = ctrl_en_q && (op_q == OP_IDLE);
  wire is_load_w  = cmd_q == 4'h0;
  wire is_erase_w = cmd_q == 4'h1;
  wire is_write_w = cmd_q == 4'h2;
  wire is_lock_w  = cmd_q == 4'h4;
  wire is_reen_w  = cmd_q == 4'h8;
  wire spm_go_w  = armed_w && spm_strobe_in && !eeprom_write_active_in;
  wire lpm_go_w  = armed_w && is_lock_w && lpm_strobe_in && (arm_age_q < `LPM_WINDOW) &&
                   !eeprom_write_active_in;
  wire timeout_w = armed_w && (arm_age_q == `SPM_WINDOW - 3'h1) && !spm_go_w && !lpm_go_w;
  wire load_w    = spm_go_w && is_load_w;
  wire reen_w    = spm_go_w && is_reen_w;
  wire start_op_w = spm_go_w && (is_erase_w || is_write_w || is_lock_w);
  wire op_done_w = (op_q != OP_IDLE) && (op_cnt_q == LAST_CNT);
  wire hold_w    = op_q != OP_IDLE;
  wire [7:0] spm_page_w = spm_pointer_in[15:8];
  wire [WA-1:0] spm_word_w = spm_pointer_in[WA:1];
  wire spm_rww_w = 32'(spm_page_w) < RWW_PAGES;
  wire eeprom_rise_w = eeprom_write_active_in && !eeprom_prev_q;
  wire buf_clr_w = (op_done_w && op_q == OP_WRITE) || (accept_w && code_w == `CODE_REEN) ||
                   (eeprom_rise_w && |buf_valid_q);
  wire [7:0] ctrl_view_w = {irq_en_q, busy_flag_q, 1'b0, cmd_q, ctrl_en_q};

  // enable bit and command latch
  always_ff @(posedge clk_in) begin
    if (reset_in && !hold_w) begin
      ctrl_en_q <= 1'b0;
      cmd_q     <= 4'h0;
      arm_age_q <= 3'h0;
    end else if (accept_w) begin
      ctrl_en_q <= 1'b1;
      cmd_q     <= code_w[4:1];
      arm_age_q <= 3'h0;
    end else if ((spm_go_w && !start_op_w) || lpm_go_w || timeout_w || op_done_w) begin
      ctrl_en_q <= 1'b0;
      cmd_q     <= 4'h0;
      arm_age_q <= 3'h0;
    end else if (armed_w) begin
      arm_age_q <= arm_age_q + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_en_q <= 1'b0;
    end else if (ctrl_wr_w) begin
      irq_en_q <= reg_wdata_in[`IE_BIT];
    end
  end

  // timed flash operation, kept running across reset
  always_ff @(posedge clk_in) begin
    if (reset_in && !hold_w) begin
      op_q        <= OP_IDLE;
      op_cnt_q    <= 16'h0000;
      op_page_q   <= 8'h00;
      op_no_read_while_write_section_q   <= 1'b0;
      lock_data_q <= 4'hF;
    end else if (start_op_w) begin
      op_q        <= is_erase_w ? OP_ERASE : (is_write_w ? OP_WRITE : OP_LOCK);
      op_cnt_q    <= 16'h0000;
      op_page_q   <= spm_page_w;
      op_no_read_while_write_section_q   <= !spm_rww_w && !is_lock_w;
      lock_data_q <= spm_data_in[5:2];
    end else if (op_done_w) begin
      op_q        <= OP_IDLE;
      op_cnt_q    <= 16'h0000;
    end else if (hold_w) begin
      op_cnt_q    <= op_cnt_q + 16'h0001;
    end
  end

  // section busy flag
  always_ff @(posedge clk_in) begin
    if (reset_in && !hold_w) begin
      busy_flag_q <= 1'b0;
    end else if (start_op_w && !is_lock_w && spm_rww_w) begin
      busy_flag_q <= 1'b1;
    end else if (reen_w || load_w) begin
      busy_flag_q <= 1'b0;
    end
  end

  // lock bits, zero data bits program
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lock_bits_q <= LOCK_INIT;
    end else if (op_done_w && op_q == OP_LOCK) begin
      lock_bits_q[5:2] <= lock_bits_q[5:2] & lock_data_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      eeprom_prev_q <= 1'b0;
    end else begin
      eeprom_prev_q <= eeprom_write_active_in;
    end
  end

  // temporary page buffer
  always_ff @(posedge clk_in) begin
    if (load_w) begin
      buf_mem[spm_word_w] <= spm_data_in;
    end
  end

  for (genvar gi = 0; gi < PAGE_WORDS; gi++) begin : g_valid
    always_ff @(posedge clk_in) begin
      if (reset_in || buf_clr_w) begin
        buf_valid_q[gi] <= 1'b0;
      end else if (load_w && spm_word_w == WA'(gi)) begin
        buf_valid_q[gi] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      buf_rd_q <= `BUF_ERASED;
    end else begin
      buf_rd_q <= buf_valid_q[buf_rd_addr_in[WA-1:0]] ? buf_mem[buf_rd_addr_in[WA-1:0]] : `BUF_ERASED;
    end
  end

  // fuse and lock readback
  wire [7:0] lpm_sel_w =
    (lpm_pointer_in == `PTR_FUSE_LOW)  ? fuse_low_byte_in :
    (lpm_pointer_in == `PTR_LOCK)      ? lock_bits_q :
    (lpm_pointer_in == `PTR_FUSE_EXT)  ? {6'h3F, extended_fuse_bits_in} :
    (lpm_pointer_in == `PTR_FUSE_HIGH) ? fuse_high_byte_in : 8'hFF;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lpm_data_q <= 8'h00;
      lpm_ovr_q  <= 1'b0;
    end else begin
      lpm_data_q <= lpm_go_w ? lpm_sel_w : 8'h00;
      lpm_ovr_q  <= lpm_go_w;
    end
  end

  // register read port
  wire [7:0] rd_sel_w = !reg_read_in ? 8'h00 : ctrl_sel_w ? ctrl_view_w : lock_sel_w ? lock_bits_q : 8'h00;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_sel_w;
    end
  end

  assign reg_rdata_out      = rdata_q;
  assign lpm_data_out       = lpm_data_q;
  assign lpm_override_out   = lpm_ovr_q;
  assign buf_rd_data_out    = buf_rd_q;
  assign flash_erase_out    = op_q == OP_ERASE;
  assign flash_write_out    = op_q == OP_WRITE;
  assign flash_page_out     = op_page_q;
  assign rww_read_block_out = busy_flag_q;
  assign cpu_halt_out       = op_no_read_while_write_section_q && (op_q == OP_ERASE || op_q == OP_WRITE);
  assign spm_irq_out        = irq_en_q && !ctrl_en_q;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence arm_seq;
    accept_w ##1 ctrl_en_q;
  endsequence

  sequence idle_window_seq;
    (!spm_strobe_in && !lpm_strobe_in) [*4];
  endsequence

  arm_timeout_a: assert property (
    arm_seq ##0 idle_window_seq |=> !ctrl_en_q)
    else $error("enable bit did not clear after four idle cycles");

  arm_hold_a: assert property (
    arm_seq ##0 (!spm_strobe_in && !lpm_strobe_in) [*3] |-> ctrl_en_q)
    else $error("enable bit cleared before the window closed");

  load_store_a: assert property (
    load_w |=> buf_valid_q[$past(spm_word_w)])
    else $error("buffer word not marked after load");

  write_clears_a: assert property (
    (op_done_w && op_q == OP_WRITE) |=> (buf_valid_q == '0) && !ctrl_en_q)
    else $error("buffer or enable not cleared after page write");

  eeprom_discard_a: assert property (
    (eeprom_rise_w && |buf_valid_q) |=> buf_valid_q == '0)
    else $error("buffer kept data across eeprom write start");

  busy_set_a: assert property (
    (start_op_w && !is_lock_w && spm_rww_w) |=> (busy_flag_q && rww_read_block_out) [*2])
    else $error("section busy flag not raised by rww programming");

  lock_no_block_a: assert property (
    (op_q == OP_LOCK) |-> !cpu_halt_out && $stable(busy_flag_q))
    else $error("lock programming blocked flash reads");

  halt_no_read_while_write_section_a: assert property (
    (start_op_w && is_write_w && !spm_rww_w) |=> cpu_halt_out && flash_write_out)
    else $error("cpu not halted for no_read_while_write_section page write");

  irq_level_a: assert property (
    (irq_en_q && !ctrl_en_q) |-> spm_irq_out ##1 (spm_irq_out == (irq_en_q && !ctrl_en_q)))
    else $error("interrupt level does not follow enable bit");

  eeprom_block_a: assert property (
    (eeprom_write_active_in && ctrl_wr_w) |=> !$rose(ctrl_en_q))
    else $error("control write accepted during eeprom write");

  lock_read_a: assert property (
    (lpm_go_w && lpm_pointer_in == `PTR_LOCK) |=> lpm_override_out && lpm_data_out == $past(lock_bits_q)
      && !ctrl_en_q)
    else $error("lock read returned wrong value");

  reenable_a: assert property (
    reen_w |=> !busy_flag_q && !ctrl_en_q)
    else $error("reenable did not clear busy flag");

  prog_time_a: assert property (
    op_done_w |=> !hold_w && !flash_erase_out && !flash_write_out && !ctrl_en_q)
    else $error("programming time count wrong");

  bad_code_a: assert property (
    (ctrl_wr_w && !code_ok_w && !ctrl_en_q) |=> !ctrl_en_q)
    else $error("invalid control code took effect");

  load_clears_busy_a: assert property (
    load_w |=> !busy_flag_q)
    else $error("page load left the busy flag set");

  busy_keeps_a: assert property (
    (busy_flag_q && !reen_w && !load_w) |=> busy_flag_q)
    else $error("busy flag dropped without reenable or load");

  reen_clears_buf_a: assert property (
    (accept_w && code_w == `CODE_REEN) |=> buf_valid_q == '0)
    else $error("reenable write left buffer words loaded");

  lock_bits_set_a: assert property (
    (op_done_w && op_q == OP_LOCK) |=> lock_bits_q[5:2] == ($past(lock_bits_q[5:2]) & $past(lock_data_q)))
    else $error("boot lock bits do not follow zero data bits");

  lock_only_boot_a: assert property (
    (op_done_w && op_q == OP_LOCK) |=> lock_bits_q[7:6] == $past(lock_bits_q[7:6])
      && lock_bits_q[1:0] == $past(lock_bits_q[1:0]))
    else $error("lock set touched bits other than boot locks");

  fuse_low_read_a: assert property (
    (lpm_go_w && lpm_pointer_in == `PTR_FUSE_LOW) |=> lpm_data_out == $past(fuse_low_byte_in))
    else $error("fuse low read returned wrong value");

  fuse_high_read_a: assert property (
    (lpm_go_w && lpm_pointer_in == `PTR_FUSE_HIGH) |=> lpm_data_out == $past(fuse_high_byte_in))
    else $error("fuse high read returned wrong value");

  fuse_ext_read_a: assert property (
    (lpm_go_w && lpm_pointer_in == `PTR_FUSE_EXT) |=> lpm_data_out[1:0] == $past(extended_fuse_bits_in))
    else $error("extended fuse read returned wrong value");

  eeprom_lpm_block_a: assert property (
    (eeprom_write_active_in && lpm_strobe_in) |=> !lpm_override_out)
    else $error("fuse or lock read served during eeprom write");

  page_latch_a: assert property (
    start_op_w |=> flash_page_out == $past(spm_pointer_in[15:8]))
    else $error("page number not taken from pointer high byte");

  op_step_a: assert property (
    (hold_w && !op_done_w) |=> hold_w && op_cnt_q == $past(op_cnt_q) + 16'h0001)
    else $error("flash operation ended before its programming time");

endmodule : self_program_flash_sequencer

`default_nettype wire

// *** core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic            clk_in,
  input  wire logic            halt_in,
  output self_prog_pkg::word_t pointer_out,
  output self_prog_pkg::word_t data_out,
  output logic                 spm_out,
  output logic                 lpm_out
);
  import self_prog_pkg::*;
  initial {pointer_out, data_out, spm_out, lpm_out} = 34'h0;
  // one store or load for one cycle; released lines show the inverse
  task automatic issue(input logic is_lpm, input word_t p, input word_t d);
    for (int n = 0; n < 200 && halt_in === 1'b1; n++) begin
      @(posedge clk_in);
    end
    @(posedge clk_in);
    {pointer_out, data_out, spm_out, lpm_out} <= {p, d, !is_lpm, is_lpm};
    @(posedge clk_in);
    {pointer_out, data_out, spm_out, lpm_out} <= {~p, ~d, 2'b00};
  endtask : issue
endmodule : core_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import self_prog_pkg::*;
  localparam int PROG = 8;
  typedef struct {word_t ptr; byte_t exp;} row_s;
  logic       clk_in = 1'b0, reset_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic       eeprom_write_active_in = 1'b0, spm, load_program_instr, lpm_override_out, flash_erase_out;
  logic       flash_write_out, rww_read_block_out, cpu_halt_out, spm_irq_out;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, flash_page_out;
  logic [6:0] buf_rd_addr_in = 7'h00;
  byte_t      lpm_data_out, v;
  word_t      buf_rd_data_out, ptr, dat;
  int         error_cnt = 0, check_count = 0;
  row_s       rows [5] = '{'{16'h0000, 8'hA5}, '{16'h0001, 8'hFF}, '{16'h0002, 8'hFE},
                          '{16'h0003, 8'h3C}, '{16'h0004, 8'hFF}};
  always #50 clk_in = ~clk_in;
  self_program_flash_sequencer #(.PROG_CYCLES(PROG)) i_self_program_flash_sequencer (
    .clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .spm_strobe_in(spm), .spm_pointer_in(ptr), .spm_data_in(dat), .lpm_strobe_in(load_program_instr),
    .lpm_pointer_in(ptr), .lpm_data_out, .lpm_override_out, .eeprom_write_active_in,
    .fuse_low_byte_in(8'hA5), .fuse_high_byte_in(8'h3C), .extended_fuse_bits_in(2'b10),
    .flash_erase_out, .flash_write_out, .flash_page_out, .buf_rd_addr_in, .buf_rd_data_out,
    .rww_read_block_out, .cpu_halt_out, .spm_irq_out);
  core_model i_core_model (.clk_in, .halt_in(cpu_halt_out), .pointer_out(ptr), .data_out(dat),
    .spm_out(spm), .lpm_out(load_program_instr));
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_flag
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {reg_addr_in, reg_wdata_in, reg_write_in, reg_read_in} <= {a, d, is_wr, !is_wr};
    @(posedge clk_in);
    {reg_write_in, reg_read_in} <= 2'b00;
    #1;
    v = reg_rdata_out;
  endtask : bus
  task automatic reg_chk(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 8'h00);
    chk_val({8'h00, v}, exp);
  endtask : reg_chk
  task automatic rd_buf(input logic [6:0] a, input word_t exp);
    @(posedge clk_in);
    buf_rd_addr_in <= a;
    @(posedge clk_in);
    #1;
    chk_val(buf_rd_data_out, exp);
  endtask : rd_buf
  task automatic cmd(input byte_t c, input logic is_lpm, input word_t p, input word_t d);
    bus(1'b1, 8'h00, c);
    i_core_model.issue(is_lpm, p, d);
    #1;
  endtask : cmd
  task automatic op_len(input int exp);
    int k;
    k = 0;
    while ((flash_write_out | flash_erase_out) === 1'b1 && k < 100) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    chk_val(16'(k), 16'(exp));
  endtask : op_len
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    reg_chk(8'h00, 16'h0000);
    reg_chk(8'h01, 16'h00FF);
    reg_chk(8'h05, 16'h0000);
    chk_flag(spm_irq_out, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(8'h09, 1'b1, rows[i].ptr, 16'h0000);
      chk_flag(lpm_override_out, 1'b1);
      chk_val({8'h00, lpm_data_out}, {8'h00, rows[i].exp});
    end
    reg_chk(8'h00, 16'h0000);
    $display("test fuse read done");
    cmd(8'h01, 1'b0, 16'h000A, 16'h1234);
    rd_buf(7'h05, 16'h1234);
    reg_chk(8'h00, 16'h0000);
    $display("test load done");
    cmd(8'h85, 1'b0, 16'h0300, 16'hDEAD);
    chk_flag(flash_write_out, 1'b1);
    chk_val({8'h00, flash_page_out}, 16'h0003);
    chk_flag(rww_read_block_out, 1'b1);
    chk_flag(spm_irq_out, 1'b0);
    op_len(PROG);
    rd_buf(7'h05, 16'hFFFF);
    chk_flag(spm_irq_out, 1'b1);
    reg_chk(8'h00, 16'h00C0);
    cmd(8'h01, 1'b0, 16'h0006, 16'h5A5A);
    chk_flag(rww_read_block_out, 1'b0);
    cmd(8'h91, 1'b0, 16'h0000, 16'h0000);
    rd_buf(7'h03, 16'hFFFF);
    bus(1'b1, 8'h00, 8'h00);
    chk_flag(spm_irq_out, 1'b0);
    $display("test page write done");
    cmd(8'h01, 1'b0, 16'h0002, 16'hBEEF);
    @(posedge clk_in);
    eeprom_write_active_in <= 1'b1;
    cmd(8'h09, 1'b1, 16'h0001, 16'h0000);
    chk_flag(lpm_override_out, 1'b0);
    @(posedge clk_in);
    eeprom_write_active_in <= 1'b0;
    rd_buf(7'h01, 16'hFFFF);
    $display("test eeprom done");
    cmd(8'h05, 1'b0, 16'hE000, 16'h0000);
    chk_flag(cpu_halt_out, 1'b1);
    chk_flag(rww_read_block_out, 1'b0);
    op_len(PROG);
    chk_flag(cpu_halt_out, 1'b0);
    $display("test upper page write done");
    bus(1'b1, 8'h00, 8'h01);
    repeat (3) @(posedge clk_in);
    i_core_model.issue(1'b0, 16'h0010, 16'h7777);
    rd_buf(7'h08, 16'hFFFF);
    bus(1'b1, 8'h00, 8'h09);
    repeat (2) @(posedge clk_in);
    i_core_model.issue(1'b1, 16'h0001, 16'h0000);
    #1;
    chk_flag(lpm_override_out, 1'b0);
    repeat (2) @(posedge clk_in);
    bus(1'b1, 8'h00, 8'h07);
    reg_chk(8'h00, 16'h0000);
    $display("test timeout done");
    cmd(8'h09, 1'b0, 16'h0001, 16'h00EB);
    chk_flag(rww_read_block_out, 1'b0);
    chk_flag(cpu_halt_out, 1'b0);
    repeat (PROG + 2) @(posedge clk_in);
    reg_chk(8'h01, 16'h00EB);
    cmd(8'h09, 1'b1, 16'h0001, 16'h0000);
    chk_val({8'h00, lpm_data_out}, 16'h00EB);
    $display("test lock set done");
    cmd(8'h03, 1'b0, 16'h0500, 16'h0000);
    @(posedge clk_in);
    reset_in <= 1'b1;
    @(posedge clk_in);
    reset_in <= 1'b0;
    #1;
    chk_flag(flash_erase_out, 1'b1);
    op_len(PROG - 2);
    chk_flag(rww_read_block_out, 1'b1);
    cmd(8'h11, 1'b0, 16'h0000, 16'h0000);
    chk_flag(rww_read_block_out, 1'b0);
    $display("test reset during erase done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
